// [core/mcp_ctrl.v]
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "mcp_consts.vh"

module mcp_ctrl #(
   parameter INIT_CYCLES = `MCP_INIT_CYC
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // host control pins
   input wire tx_off_request,
   input wire sleep_restart,
   input wire bus_deselect,
   // module internals
   input wire fault_in,
   input wire signal_present,
   output reg tx_emit,
   // host status pins
   output reg not_ready_flag,
   output reg rx_signal_lost,
   output reg irq,
   // management access
   input wire mgmt_req,
   input wire [7:0] mgmt_addr,
   output reg mgmt_enable,
   output reg mgmt_ack
);

   localparam [2:0] ST_INIT = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_DOWN = 3'b100;
   localparam [31:0] INIT_LAST = INIT_CYCLES - 1;

   localparam [2:0] IDX_CTRL = 3'h0;
   localparam [2:0] IDX_STATUS = 3'h1;
   localparam [2:0] IDX_IRQ_STATUS = 3'h2;
   localparam [2:0] IDX_IRQ_ENABLE = 3'h3;
   localparam [2:0] IDX_IRQ_CLEAR = 3'h4;
   localparam [2:0] IDX_NONE = 3'h7;

   function [2:0] reg_index;
      input [11:0] addr;
      begin
         case ({addr[11:2], 2'b00})
            `MCP_OFS_CTRL: reg_index = IDX_CTRL;
            `MCP_OFS_STATUS: reg_index = IDX_STATUS;
            `MCP_OFS_IRQ_STATUS: reg_index = IDX_IRQ_STATUS;
            `MCP_OFS_IRQ_ENABLE: reg_index = IDX_IRQ_ENABLE;
            `MCP_OFS_IRQ_CLEAR: reg_index = IDX_IRQ_CLEAR;
            default: reg_index = IDX_NONE;
         endcase
      end
   endfunction

   reg [2:0] state;
   reg [22:0] init_cnt;
   reg long_hold_seen;
   reg [1:0] ctrl;
   reg [3:0] irq_status;
   reg [3:0] irq_enable;
   reg fault_q;
   reg desel_q;
   reg los_q;
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [31:0] next_rdata;
   reg [3:0] read_clear;
   reg [3:0] write_clear;
   reg [3:0] events;

   wire reset_held;
   wire signal_settled;
   wire wr_fire;
   wire rd_fire;
   wire restart;
   wire init_done;
   wire [2:0] wr_idx;
   wire [2:0] rd_idx;

   // sleep_restart long enough for a full restart
   mcp_hold #(
      .HOLD_CYC(`MCP_RESET_MIN_CYC)
   ) u_reset_hold (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(sleep_restart),
      .held(reset_held)
   );

   // signal present long enough to drop loss
   mcp_hold #(
      .HOLD_CYC(`MCP_LOS_OFF_CYC)
   ) u_los_hold (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(signal_present),
      .held(signal_settled)
   );

   assign wr_idx = reg_index(aw_addr);
   assign rd_idx = reg_index(s_axi_araddr);
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign restart = (state == ST_DOWN) && !sleep_restart && (long_hold_seen || reset_held);
   assign init_done = (state == ST_INIT) && !sleep_restart && ({9'h000, init_cnt} == INIT_LAST);

   // power sequence
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_INIT;
         init_cnt <= 23'h000000;
         long_hold_seen <= 1'b0;
      end else begin
         case (state)
            ST_INIT: begin
               if (sleep_restart) begin
                  state <= ST_DOWN;
                  init_cnt <= 23'h000000;
               end else if (init_done) begin
                  state <= ST_RUN;
                  init_cnt <= 23'h000000;
               end else begin
                  init_cnt <= init_cnt + 23'h000001;
               end
            end
            ST_RUN: begin
               if (sleep_restart) begin
                  state <= ST_DOWN;
               end
            end
            ST_DOWN: begin
               if (reset_held) begin
                  long_hold_seen <= 1'b1;
               end
               if (!sleep_restart) begin
                  long_hold_seen <= 1'b0;
                  // a hold of exactly the minimum shows only in reset_held here
                  state <= (long_hold_seen || reset_held) ? ST_INIT : ST_RUN;
               end
            end
            default: begin
               state <= ST_INIT;
            end
         endcase
      end
   end

   // pins toward the host
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_emit <= 1'b0;
         not_ready_flag <= 1'b1;
         rx_signal_lost <= 1'b1;
         mgmt_enable <= 1'b0;
         mgmt_ack <= 1'b0;
         fault_q <= 1'b0;
         desel_q <= 1'b0;
         los_q <= 1'b1;
      end else begin
         tx_emit <= !tx_off_request && !ctrl[`MCP_CTRL_SOFT_TX_OFF] && (state == ST_RUN);
         not_ready_flag <= fault_in || (state != ST_RUN);
         if (!signal_present) begin
            rx_signal_lost <= 1'b1;
         end else if (signal_settled) begin
            rx_signal_lost <= 1'b0;
         end
         mgmt_enable <= !bus_deselect && (state == ST_RUN);
         mgmt_ack <= mgmt_req && !bus_deselect && (state == ST_RUN)
                     && (!mgmt_addr[`MCP_MGMT_UPPER_BIT] || ctrl[`MCP_CTRL_UPPER_EN]);
         fault_q <= fault_in;
         desel_q <= bus_deselect;
         los_q <= rx_signal_lost;
      end
   end

   // interrupt sources and clears
   always @* begin
      events = `MCP_EV_RESET;
      events[`MCP_EV_INIT_DONE] = init_done;
      events[`MCP_EV_LOS] = rx_signal_lost && !los_q;
      events[`MCP_EV_FAULT] = fault_in && !fault_q;
      events[`MCP_EV_DESEL] = bus_deselect != desel_q;
      read_clear = `MCP_EV_RESET;
      if (rd_fire && (rd_idx == IDX_IRQ_STATUS)) begin
         read_clear = irq_status;
      end
      write_clear = `MCP_EV_RESET;
      if (wr_fire && (wr_idx == IDX_IRQ_CLEAR) && w_strb[0]) begin
         write_clear = w_data[3:0];
      end
   end

   // interrupt status, enable and control
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `MCP_EV_RESET;
         irq_enable <= `MCP_EV_RESET;
         ctrl <= `MCP_CTRL_RESET;
         irq <= 1'b0;
      end else if (restart) begin
         irq_status <= `MCP_EV_RESET;
         irq_enable <= `MCP_EV_RESET;
         ctrl <= `MCP_CTRL_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~(read_clear | write_clear)) | events;
         irq <= |(((irq_status & ~(read_clear | write_clear)) | events) & irq_enable);
         if (wr_fire && w_strb[0]) begin
            if (wr_idx == IDX_IRQ_ENABLE) begin
               irq_enable <= w_data[3:0];
            end
            if (wr_idx == IDX_CTRL) begin
               ctrl <= w_data[1:0];
            end
         end
      end
   end

   // read data mux
   always @* begin
      next_rdata = 32'h00000000;
      case (rd_idx)
         IDX_CTRL: next_rdata[1:0] = ctrl;
         IDX_STATUS: begin
            next_rdata[`MCP_ST_READY] = !not_ready_flag;
            next_rdata[`MCP_ST_TX_EMIT] = tx_emit;
            next_rdata[`MCP_ST_LOS] = rx_signal_lost;
            next_rdata[`MCP_ST_MGMT_EN] = mgmt_enable;
            next_rdata[`MCP_ST_POWER_DOWN] = (state == ST_DOWN);
         end
         IDX_IRQ_STATUS: next_rdata[3:0] = irq_status;
         IDX_IRQ_ENABLE: next_rdata[3:0] = irq_enable;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // axi4-lite write channels, either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MCP_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if ((wr_idx == IDX_NONE) || (wr_idx == IDX_STATUS) || (wr_idx == IDX_IRQ_STATUS)) begin
               s_axi_bresp <= `MCP_RESP_SLVERR;
            end else begin
               s_axi_bresp <= `MCP_RESP_OKAY;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read channels
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `MCP_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         if ((rd_idx == IDX_NONE) || (rd_idx == IDX_IRQ_CLEAR)) begin
            s_axi_rresp <= `MCP_RESP_SLVERR;
         end else begin
            s_axi_rresp <= `MCP_RESP_OKAY;
         end
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // mcp_ctrl

// [core/mcp_hold.v]
`timescale 1ns/1ps
`include "mcp_consts.vh"

// high once level_in has stood high for HOLD_CYC consecutive cycles
module mcp_hold #(
   parameter HOLD_CYC = 8
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // level
   input wire level_in,
   output reg held
);

   reg [11:0] count;

   always @(posedge aclk) begin
      if (!aresetn) begin
         count <= 12'h000;
         held <= 1'b0;
      end else if (!level_in) begin
         count <= 12'h000;
         held <= 1'b0;
      end else if (count == HOLD_CYC[11:0] - 12'h001) begin
         held <= 1'b1;
      end else begin
         count <= count + 12'h001;
      end
   end

endmodule // mcp_hold

// [pkg/mcp_consts.vh]
`ifndef MCP_CONSTS_VH
`define MCP_CONSTS_VH

// clock
`define MCP_CLK_NS 50

// pin timing, figures in their own units
`define MCP_T_INIT_MS 300
`define MCP_T_RESET_MIN_NS 10000
`define MCP_T_LOS_OFF_MIN_NS 2300

// cycle counts: least times round up, longest times round down
`define MCP_INIT_CYC ((`MCP_T_INIT_MS * 1000000) / `MCP_CLK_NS)
`define MCP_RESET_MIN_CYC ((`MCP_T_RESET_MIN_NS + `MCP_CLK_NS - 1) / `MCP_CLK_NS)
`define MCP_LOS_OFF_CYC ((`MCP_T_LOS_OFF_MIN_NS + `MCP_CLK_NS - 1) / `MCP_CLK_NS)

// management address space
`define MCP_MGMT_UPPER_BIT 7

// register byte offsets
`define MCP_OFS_CTRL 12'h000
`define MCP_OFS_STATUS 12'h004
`define MCP_OFS_IRQ_STATUS 12'h008
`define MCP_OFS_IRQ_ENABLE 12'h00C
`define MCP_OFS_IRQ_CLEAR 12'h010

// control fields
`define MCP_CTRL_UPPER_EN 0
`define MCP_CTRL_SOFT_TX_OFF 1
`define MCP_CTRL_RESET 2'h0

// status fields
`define MCP_ST_READY 0
`define MCP_ST_TX_EMIT 1
`define MCP_ST_LOS 2
`define MCP_ST_MGMT_EN 3
`define MCP_ST_POWER_DOWN 4

// interrupt event fields
`define MCP_EV_INIT_DONE 0
`define MCP_EV_LOS 1
`define MCP_EV_FAULT 2
`define MCP_EV_DESEL 3
`define MCP_EV_RESET 4'h0

// axi responses
`define MCP_RESP_OKAY 2'h0
`define MCP_RESP_SLVERR 2'h2

`endif

// [sim/mcp_ctrl_asserts.sv]
`timescale 1ns/1ps
`include "mcp_consts.vh"
module mcp_ctrl_asserts #(
   parameter INIT_CYCLES = 20
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi handshakes
   input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire s_axi_bvalid, s_axi_bready,
   input wire [1:0] s_axi_bresp,
   // pins
   input wire tx_off_request, tx_emit, fault_in, not_ready_flag,
   input wire signal_present, rx_signal_lost, sleep_restart, irq,
   input wire bus_deselect, mgmt_req, mgmt_enable, mgmt_ack,
   input wire [7:0] mgmt_addr
);
   reg [11:0] hi_cnt;
   // cycles the incoming signal has stood present
   always @(posedge aclk) begin
      if (!aresetn || !signal_present) hi_cnt <= 12'h000;
      else if (hi_cnt != 12'hFFF) hi_cnt <= hi_cnt + 12'h001;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_tx_off: assert property (tx_off_request |=> !tx_emit)
      else $error("laser still on after off request");
   a_fault_nr: assert property (fault_in |=> not_ready_flag)
      else $error("not ready missing after fault");
   a_pdown_on: assert property (sleep_restart |-> ##[1:2] not_ready_flag)
      else $error("power down not entered");
   a_los_on: assert property (!signal_present |=> rx_signal_lost)
      else $error("signal loss not flagged");
   a_los_min: assert property ($fell(rx_signal_lost) |-> hi_cnt >= `MCP_LOS_OFF_CYC)
      else $error("signal loss cleared too early");
   a_los_max: assert property (hi_cnt > 12'h7D0 |-> !rx_signal_lost)
      else $error("signal loss cleared too late");
   a_desel_off: assert property (bus_deselect |=> !mgmt_enable)
      else $error("management still on when deselected");
   a_lower_open: assert property (mgmt_req && !mgmt_addr[7] && mgmt_enable && !bus_deselect
      && !sleep_restart && !$past(sleep_restart) |=> mgmt_ack)
      else $error("lower half not answered");
   a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   c_irq: cover property ($rose(irq));
   c_los: cover property ($fell(rx_signal_lost));
   c_desel: cover property (bus_deselect && mgmt_req);
endmodule // mcp_ctrl_asserts

bind mcp_ctrl mcp_ctrl_asserts #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);

// [sim/mcp_host.sv]
`timescale 1ns/1ps
`include "mcp_consts.vh"
module mcp_host #(
   parameter GAP = 50,
   parameter HOLD = `MCP_RESET_MIN_CYC
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // bench commands
   input wire want_off, want_desel, want_sleep, want_restart, go,
   input wire [7:0] addr,
   output reg done, got,
   // pins toward the module
   output reg tx_off_request, sleep_restart, bus_deselect, mgmt_req,
   output reg [7:0] mgmt_addr,
   input wire mgmt_ack
);
   reg [7:0] gap, hold;
   reg [1:0] wt;
   always @(posedge aclk) begin
      if (!aresetn) begin
         {tx_off_request, sleep_restart, bus_deselect, mgmt_req, done, got} <= 6'h00;
         {gap, hold, mgmt_addr, wt} <= 26'h0;
      end else begin
         tx_off_request <= want_off;
         bus_deselect <= want_desel;
         hold <= want_restart ? 8'(HOLD) : (hold != 8'h00 ? hold - 8'h01 : 8'h00);
         sleep_restart <= want_sleep || want_restart || hold != 8'h00;
         done <= 1'b0;
         mgmt_req <= 1'b0;
         mgmt_addr <= ~mgmt_addr;
         if (gap != 8'h00) gap <= gap - 8'h01;
         if (wt != 2'h0) wt <= wt - 2'h1;
         if (wt == 2'h1) begin
            got <= mgmt_ack;
            done <= 1'b1;
         end
         // clock no faster than 400 kHz
         if (go && gap == 8'h00 && wt == 2'h0) begin
            mgmt_req <= 1'b1;
            mgmt_addr <= addr;
            gap <= 8'(GAP);
            wt <= 2'h2;
         end
      end
   end
endmodule // mcp_host

// [sim/tb.sv]
`timescale 1ns/1ps
`include "mcp_consts.vh"
module tb;
   logic aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 24408, d, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, fault_in = 0, signal_present = 1, tx_emit, not_ready_flag;
   logic rx_signal_lost, irq, tx_off_request, sleep_restart, bus_deselect, mgmt_req;
   logic mgmt_enable, mgmt_ack, done, got, g, fin;
   logic want_off = 0, want_desel = 0, want_sleep = 0, want_restart = 0, go = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] mgmt_addr, addr = 0;
   int err_count = 0, check_count = 0, n;
   initial forever #25 aclk = ~aclk;
   mcp_ctrl #(.INIT_CYCLES(20)) dut (.*);
   mcp_host hst (.*);
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task step(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task wr(input [11:0] a, input [31:0] x, output [1:0] rs);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fin = 0;
      while (!fin) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            fin = 1;
         end
      end
      @(posedge aclk);
   endtask
   task rd(input [11:0] a, output [31:0] x, output [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      fin = 0;
      while (!fin) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            x = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            fin = 1;
         end
      end
      @(posedge aclk);
   endtask
   task mg(input [7:0] a, output o);
      addr <= a;
      go <= 1'b1;
      for (n = 0; n < 300 && !done; n++) @(posedge aclk);
      go <= 1'b0;
      check(done, 1);
      o = got;
      @(posedge aclk);
   endtask
   task wait_rdy(input int k);
      for (n = 0; n < k && not_ready_flag !== 1'b0; n++) @(posedge aclk);
   endtask
   task results;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #(50 * 20000);
      err_count++;
      results;
   end
   initial begin
      step(16);
      aresetn <= 1'b1;
      wait_rdy(60);
      check(not_ready_flag, 0);
      rd(`MCP_OFS_IRQ_STATUS, d, r);
      check(d[0], 1);
      rd(`MCP_OFS_IRQ_ENABLE, d, r);
      check(d, 0);
      s_axi_wstrb <= 4'hE;
      wr(`MCP_OFS_IRQ_ENABLE, 32'hF, r);
      s_axi_wstrb <= 4'hF;
      check(r, `MCP_RESP_OKAY);
      rd(`MCP_OFS_IRQ_ENABLE, d, r);
      check(d, 0);
      rd(12'h020, d, r);
      check(r, `MCP_RESP_SLVERR);
      rd(`MCP_OFS_IRQ_CLEAR, d, r);
      check(r, `MCP_RESP_SLVERR);
      wr(`MCP_OFS_STATUS, 32'h1, r);
      check(r, `MCP_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         d = rnd();
         wr(`MCP_OFS_CTRL, d, r);
         rd(`MCP_OFS_STATUS, v, r);
         check(v[1], !d[1]);
         mg({1'b1, d[6:0]}, g);
         check(g, d[0]);
      end
      wr(`MCP_OFS_CTRL, 32'h0, r);
      want_off <= 1'b1;
      step(3);
      check(tx_emit, 0);
      want_off <= 1'b0;
      step(3);
      check(tx_emit, 1);
      wr(`MCP_OFS_IRQ_ENABLE, 32'h4, r);
      fault_in <= 1'b1;
      step(2);
      check(irq, 1);
      check(not_ready_flag, 1);
      fault_in <= 1'b0;
      step(2);
      check(not_ready_flag, 0);
      rd(`MCP_OFS_IRQ_STATUS, d, r);
      check(d[2], 1);
      step(1);
      check(irq, 0);
      wr(`MCP_OFS_IRQ_ENABLE, 32'h0, r);
      fault_in <= 1'b1;
      step(1);
      fault_in <= 1'b0;
      step(2);
      check(irq, 0);
      wr(`MCP_OFS_IRQ_ENABLE, 32'h4, r);
      step(1);
      check(irq, 1);
      wr(`MCP_OFS_IRQ_CLEAR, 32'h4, r);
      step(1);
      check(irq, 0);
      signal_present <= 1'b0;
      step(2);
      check(rx_signal_lost, 1);
      signal_present <= 1'b1;
      step(40);
      check(rx_signal_lost, 1);
      step(30);
      check(rx_signal_lost, 0);
      rd(`MCP_OFS_IRQ_STATUS, d, r);
      check(d[1], 1);
      want_desel <= 1'b1;
      step(3);
      d = rnd();
      mg({1'b0, d[6:0]}, g);
      check(g, 0);
      rd(`MCP_OFS_STATUS, v, r);
      check(v[3], 0);
      want_desel <= 1'b0;
      step(3);
      rd(`MCP_OFS_STATUS, v, r);
      check(v[3], 1);
      for (int i = 0; i < 3; i++) begin
         d = rnd();
         mg({1'b0, d[6:0]}, g);
         check(g, 1);
      end
      rd(`MCP_OFS_IRQ_STATUS, d, r);
      check(d[3], 1);
      want_sleep <= 1'b1;
      step(4);
      check(not_ready_flag, 1);
      rd(`MCP_OFS_STATUS, v, r);
      check(v[4], 1);
      want_sleep <= 1'b0;
      wait_rdy(60);
      rd(`MCP_OFS_IRQ_ENABLE, d, r);
      check(d, 32'h4);
      want_restart <= 1'b1;
      step(1);
      want_restart <= 1'b0;
      step(4);
      check(not_ready_flag, 1);
      wait_rdy(`MCP_RESET_MIN_CYC + 80);
      check(not_ready_flag, 0);
      rd(`MCP_OFS_IRQ_ENABLE, d, r);
      check(d, 0);
      results;
   end
endmodule // tb
